// *** dps_sequencer.sv ***
// Power and bring-up logic of the decoder device.
// Assumes the controller keeps the start order and initialises the input.
// Behaviour
// - Converter enable high switches on up-converter and voltage monitor.
// - Supply-good drops when sensed voltage falls below programmed threshold.
// - Wake enable powers digital part and converter; processor mode runs.
// - Converter alone keeps running for other circuits; decoding stays off.
// - Control bus transfers serviced only while wake enable is high.
`timescale 1ns/100ps
`include "dps_defs.svh"
module dps_sequencer #(
  parameter int THR_W = `DPS_THR_W
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic converter_enable_pin_in,
  input wire logic wake_enable_pin_in,
  input wire logic power_on_reset_pin_in,
  input wire logic bitstream_clock_pin_in,
  input wire logic [THR_W-1:0] supply_sense_pin_in,
  input wire logic bus_wr_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [15:0] bus_data_in,
  input wire logic bus_run_in,
  input wire logic [15:0] bus_run_cmd_in,
  input wire logic thr_wr_in,
  input wire logic [THR_W-1:0] thr_data_in,
  output logic supply_good_flag_out,
  output logic converter_on_out,
  output logic digital_on_out,
  output logic dsp_mode_out,
  output logic bus_ack_out,
  output logic serial_ready_out,
  output logic audio_enable_out,
  output logic [THR_W-1:0] threshold_out,
  output logic [3:0] state_out
);
  // ************************
  // State
  // ************************
  typedef struct packed {
    dps_pkg::dps_state_t fsm;
    logic [THR_W-1:0] thr;
    logic reg_done;
    logic serial_ready;
    logic ack;
    logic por_d;
  } dps_seq_state_t;
  dps_seq_state_t st_ff;
  dps_seq_state_t nxt_st;
  logic mon_good;
  logic bus_live;
  logic por_rise;
  logic init_clear;
  logic clk_low;
  logic thr_take;
  logic serial_wr;
  logic serial_wr_ok;
  logic run_take;
  logic run_ok;
  dps_monitor #(
    .THR_W(THR_W)
  ) u_mon (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .enable_in(converter_enable_pin_in || wake_enable_pin_in),
    .sense_in(supply_sense_pin_in),
    .threshold_in(st_ff.thr),
    .good_out(mon_good)
  );
  // ************************
  // Access decode
  // ************************
  // Accesses count only when awake and ready
  assign bus_live = wake_enable_pin_in &&
                    (st_ff.fsm == dps_pkg::DPS_READY);
  assign por_rise = power_on_reset_pin_in && !st_ff.por_d;
  // Power loss or reset pin edge dominates any set
  assign init_clear = !wake_enable_pin_in || por_rise;
  // Bitstream clock must idle low during init
  assign clk_low = !bitstream_clock_pin_in;
  assign thr_take = bus_live && thr_wr_in;
  assign serial_wr = bus_live && bus_wr_in;
  assign serial_wr_ok = serial_wr && clk_low &&
                        (bus_addr_in == `DPS_SERIAL_REG);
  assign run_take = bus_live && bus_run_in;
  assign run_ok = run_take && clk_low && st_ff.reg_done &&
                  (bus_run_cmd_in == `DPS_RUN_CMD);
  // ************************
  // Next state
  // ************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.por_d = power_on_reset_pin_in;
    nxt_st.ack = 1'b0;
    case (st_ff.fsm)
      dps_pkg::DPS_OFF: begin
        if (wake_enable_pin_in) begin
          nxt_st.fsm = dps_pkg::DPS_ACTIVE;
        end else if (converter_enable_pin_in) begin
          nxt_st.fsm = dps_pkg::DPS_STANDBY;
        end
      end
      dps_pkg::DPS_STANDBY: begin
        if (wake_enable_pin_in) begin
          nxt_st.fsm = dps_pkg::DPS_ACTIVE;
        end else if (!converter_enable_pin_in) begin
          nxt_st.fsm = dps_pkg::DPS_OFF;
        end
      end
      // Wake lost during bring-up falls straight back
      dps_pkg::DPS_ACTIVE: begin
        if (!wake_enable_pin_in) begin
          nxt_st.fsm = converter_enable_pin_in ? dps_pkg::DPS_STANDBY
                                               : dps_pkg::DPS_OFF;
        end else begin
          nxt_st.fsm = dps_pkg::DPS_READY;
        end
      end
      dps_pkg::DPS_READY: begin
        if (!wake_enable_pin_in) begin
          nxt_st.fsm = converter_enable_pin_in ? dps_pkg::DPS_STANDBY
                                               : dps_pkg::DPS_OFF;
        end
      end
      default: begin
        nxt_st.fsm = dps_pkg::DPS_OFF;
      end
    endcase
    // Init state lost on digital power-down or reset pin edge
    if (init_clear) begin
      nxt_st.reg_done = 1'b0;
      nxt_st.serial_ready = 1'b0;
    end else begin
      if (thr_take) begin
        nxt_st.thr = thr_data_in;
      end
      if (serial_wr_ok) begin
        nxt_st.reg_done = (bus_data_in == `DPS_SERIAL_VAL);
      end
      if (run_ok) begin
        nxt_st.serial_ready = 1'b1;
      end
      nxt_st.ack = thr_take || serial_wr || run_take;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff.fsm <= dps_pkg::DPS_OFF;
      st_ff.thr <= THR_W'(`DPS_THR_RST);
      st_ff.reg_done <= 1'b0;
      st_ff.serial_ready <= 1'b0;
      st_ff.ack <= 1'b0;
      st_ff.por_d <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ************************
  // Outputs
  // ************************
  // Power status
  assign supply_good_flag_out = mon_good;
  assign converter_on_out = converter_enable_pin_in || wake_enable_pin_in;
  assign digital_on_out = st_ff.fsm == dps_pkg::DPS_READY;
  assign dsp_mode_out = st_ff.fsm == dps_pkg::DPS_READY;
  // Control bus and init status
  assign bus_ack_out = st_ff.ack;
  assign serial_ready_out = st_ff.serial_ready;
  assign audio_enable_out = st_ff.serial_ready && digital_on_out;
  assign threshold_out = st_ff.thr;
  assign state_out = st_ff.fsm;
endmodule // dps_sequencer

// *** dps_defs.svh ***
// Constants for the decoder power-up sequencer.
// Assumes inclusion by bare name from the same folder.
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
`define DPS_THR_W 8
`define DPS_THR_RST 8'h80
`define DPS_SERIAL_REG 8'h3B
`define DPS_SERIAL_VAL 16'h0020
`define DPS_RUN_CMD 16'h0001
`endif

// *** dps_pkg.sv ***
// Types for the decoder power-up sequencer.
// Assumes the defs header sits in the same folder.
package dps_pkg;
  typedef enum logic [3:0] {
    DPS_OFF = 4'h1,
    DPS_STANDBY = 4'h2,
    DPS_ACTIVE = 4'h4,
    DPS_READY = 4'h8
  } dps_state_t;
endpackage

// *** dps_monitor.sv ***
// Supply monitor: compares sensed level against a programmable threshold.
// Assumes sense level already digitised and synchronous to core_clk_in.
`timescale 1ns/100ps
`include "dps_defs.svh"
module dps_monitor #(
  parameter int THR_W = `DPS_THR_W
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic [THR_W-1:0] sense_in,
  input wire logic [THR_W-1:0] threshold_in,
  output logic good_out
);
  typedef struct packed {
    logic good;
  } dps_mon_state_t;
  dps_mon_state_t st_ff;
  dps_mon_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.good = enable_in && (sense_in >= threshold_in);
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign good_out = st_ff.good;
endmodule // dps_monitor

// *** dps_properties.sv ***
// Port assertions for the decoder power-up sequencer.
// Assumes a bind to dps_sequencer with ports of the same names.
`timescale 1ns/100ps
module dps_properties #(parameter int THR_W = 8) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic converter_enable_pin_in,
  input wire logic wake_enable_pin_in,
  input wire logic [THR_W-1:0] supply_sense_pin_in,
  input wire logic [THR_W-1:0] threshold_out,
  input wire logic bus_wr_in,
  input wire logic bus_run_in,
  input wire logic supply_good_flag_out,
  input wire logic digital_on_out,
  input wire logic bus_ack_out,
  input wire logic [3:0] state_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_good_rise: assert property (
    converter_enable_pin_in && supply_sense_pin_in >= threshold_out
    |=> supply_good_flag_out) else $error("supply good missing");
  a_good_drop: assert property (
    supply_sense_pin_in < threshold_out |=> !supply_good_flag_out)
    else $error("supply good kept below threshold");
  sequence s_wake_standby;
    state_out == 4'h2 && wake_enable_pin_in;
  endsequence
  sequence s_bring_up;
    state_out == 4'h4 ##1 (state_out == 4'h8 && digital_on_out);
  endsequence
  a_wake_bringup: assert property (
    s_wake_standby ##1 wake_enable_pin_in |-> s_bring_up)
    else $error("wake did not bring digital part up");
  a_standby_quiet: assert property (
    (converter_enable_pin_in && !wake_enable_pin_in) [*2] |-> !digital_on_out)
    else $error("digital part on without wake");
  a_asleep_refuse: assert property (
    (bus_wr_in || bus_run_in) && !wake_enable_pin_in |=> !bus_ack_out)
    else $error("access served while asleep");
endmodule // dps_properties

// *** dps_ctrl_model.sv ***
// Controller model: converter first, wake after supply good settles.
// Assumes supply good arrives as a registered level.
`timescale 1ns/100ps
module dps_ctrl_model #(parameter int SETTLE = 125000) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic good_in,
  output logic cen_out,
  output logic wake_out
);
  int cnt_ff;
  always @(posedge core_clk_in) begin
    cen_out <= start_in && !rst_in;
    if (rst_in || !start_in || !good_in) cnt_ff <= 0;
    else if (cnt_ff < SETTLE) cnt_ff <= cnt_ff + 1;
    wake_out <= !rst_in && start_in && good_in
      && cnt_ff >= SETTLE;
  end
endmodule // dps_ctrl_model

// *** dps_sequencer_test.sv ***
// Bench for the decoder power-up sequencer.
// Assumes the controller model drives both enables.
`timescale 1ns/100ps
module dps_sequencer_test;
  logic core_clk_in = 0, rst_in = 1, start = 0, thr_wr_in = 0;
  logic converter_enable_pin_in, wake_enable_pin_in, power_on_reset_pin_in = 0;
  logic bitstream_clock_pin_in = 0, bus_wr_in = 0, bus_run_in = 0;
  logic [7:0] supply_sense_pin_in = 8'h90, bus_addr_in = 8'h3B;
  logic [7:0] thr_data_in = 8'hA0, threshold_out;
  logic [15:0] bus_data_in = 16'h0, bus_run_cmd_in = 16'h1;
  logic supply_good_flag_out, converter_on_out, digital_on_out, dsp_mode_out;
  logic bus_ack_out, serial_ready_out, audio_enable_out;
  logic [3:0] state_out;
  int err_total = 0, checks = 0;
  initial forever #4 core_clk_in = ~core_clk_in;
  dps_sequencer i_dut (.*);
  dps_ctrl_model #(.SETTLE(8)) i_ctrl (.core_clk_in, .rst_in,
    .start_in(start), .good_in(supply_good_flag_out),
    .cen_out(converter_enable_pin_in), .wake_out(wake_enable_pin_in));
  task chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      $display("wrong value at %0t: %h expected %h", $time, g, x);
      err_total++;
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task acc(input logic w, input logic [15:0] d, input logic e);
    @(posedge core_clk_in) #1 {bus_wr_in, bus_run_in, bus_data_in} = {w, !w, d};
    @(posedge core_clk_in) #1 {bus_wr_in, bus_run_in} = 2'h0;
    chk(bus_ack_out, e);
  endtask
  initial begin
    repeat (12) @(posedge core_clk_in);
    #1 rst_in = 0;
    chk(threshold_out, 8'h80);
    chk(state_out, 4'h1);
    acc(1, 16'h20, 0);
    start = 1;
    for (int i = 0; i < 99 && state_out !== 4'h8; i++)
      @(posedge core_clk_in) #1;
    chk(state_out, 4'h8);
    if (state_out !== 4'h8) results();
    chk(supply_good_flag_out, 1);
    chk({digital_on_out, dsp_mode_out}, 2'h3);
    bitstream_clock_pin_in = 1;
    acc(1, 16'h20, 1);
    acc(0, 16'h1, 1);
    chk(serial_ready_out, 0);
    bitstream_clock_pin_in = 0;
    acc(1, 16'h20, 1);
    acc(0, 16'h1, 1);
    chk(audio_enable_out, 1);
    @(posedge core_clk_in) #1 power_on_reset_pin_in = 1;
    @(posedge core_clk_in) #1 power_on_reset_pin_in = 0;
    chk(serial_ready_out, 0);
    chk(audio_enable_out, 0);
    thr_wr_in = 1;
    @(posedge core_clk_in) #1 thr_wr_in = 0;
    #64;
    chk(threshold_out, 8'hA0);
    chk(supply_good_flag_out, 0);
    chk({converter_on_out, digital_on_out}, 2'h2);
    results();
  end
endmodule // dps_sequencer_test
bind dps_sequencer dps_properties #(.THR_W(THR_W)) i_props (.*);
